// File: inc/adcrt_pkg.sv
/*
 * Package of the converter result and trigger control block: register
 * indices, field positions, reset values and the packed carriers.
 * Assumes a 32-bit APB bus that addresses one aligned word per register.
 */
package adcrt_pkg;

   // ************************************************************
   // Register indices (byte address is four times the index)
   // ************************************************************
   localparam logic [5:0] IDX_PIN_DISABLE = 6'h01;
   localparam logic [5:0] IDX_CTRL_B      = 6'h03;
   localparam logic [5:0] IDX_RESULT_LOW  = 6'h04;
   localparam logic [5:0] IDX_RESULT_HIGH = 6'h05;
   localparam logic [5:0] IDX_CTRL_A      = 6'h06;
   localparam logic [5:0] IDX_IRQ_STATUS  = 6'h07;
   localparam logic [5:0] IDX_IRQ_MASK    = 6'h08;

   // ************************************************************
   // Field positions and reset values
   // ************************************************************
   localparam int         CTRL_A_ENABLE   = 7;
   localparam int         CTRL_A_START    = 6;
   localparam int         CTRL_A_AUTO     = 5;
   localparam int         CTRL_A_FLAG     = 4;
   localparam int         IRQ_COMPLETE    = 0;
   localparam int         IRQ_DISCARD     = 1;
   localparam logic [7:0] RST_PIN_DISABLE = 8'h00;
   localparam logic [7:0] RST_CTRL_B      = 8'h00;
   localparam logic [9:0] RST_RESULT      = 10'h000;
   localparam logic [1:0] RST_IRQ         = 2'h0;
   localparam logic [9:0] SATURATED       = 10'h3ff;
   localparam logic [2:0] SRC_FREE_RUN    = 3'h0;

   // ************************************************************
   // Carriers
   // ************************************************************
   typedef struct packed {
      logic       bipolar_select;
      logic       comparator_mux;
      logic       spare_5;
      logic       left_justify_bit;
      logic       spare_3;
      logic [2:0] trigger_source_field;
   } adcrt_ctrl_b_t;

   typedef struct packed {
      logic       done;
      logic       neg;
      logic [9:0] value;
   } adcrt_conv_t;

   typedef struct packed {
      logic [7:0]  paddr;
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [31:0] pwdata;
   } adcrt_apb_req_t;

endpackage : adcrt_pkg

// File: verilog/adcrt_core.sv
/*
 * Converter result, trigger and pin input disable control, APB slave.
 * Assumes the analog converter reports each finished conversion with a
 * one-cycle done pulse on core_clk_i, and that trigger flags are on-chip
 * levels on the same clock; the port pins are asynchronous.
 */
`timescale 1ns/10ps
`default_nettype none

module adcrt_core (
   input  wire logic                      core_clk_i,
   input  wire logic                      reset_n_i,
   input  wire adcrt_pkg::adcrt_apb_req_t apb_req_i,
   output logic [31:0]                    prdata_o,
   output logic                           pready_o,
   output logic                           pslverr_o,
   output logic                           irq_o,
   input  wire adcrt_pkg::adcrt_conv_t    conv_i,
   input  wire logic [6:0]                trig_flags_i,
   output logic                           conv_start_o,
   output logic                           conv_enable_o,
   output logic                           conv_bipolar_o,
   input  wire logic [7:0]                port_pin_i,
   output logic [7:0]                     port_pin_o,
   output logic [7:0]                     pin_buffer_enable_o
);

   // ************************************************************
   // Register state
   // ************************************************************
   logic [7:0]              analog_pin_input_disable;
   adcrt_pkg::adcrt_ctrl_b_t converter_control_b;
   logic                    converter_enable;
   logic                    auto_trigger_enable;
   logic                    busy;
   logic [9:0]              conversion_result_bits;
   logic                    read_lock;
   logic [1:0]              irq_status;
   logic [1:0]              irq_mask;
   logic                    prev_trigger;
   logic [7:0]              pin_meta;
   logic [7:0]              pin_sync;

   logic [5:0]  reg_idx;
   logic        setup_phase;
   logic        access_done;
   logic        wr_en;
   logic        rd_en;
   logic        mapped;
   logic [7:0]  wdata;
   logic [7:0]  result_low;
   logic [7:0]  result_high;
   logic [7:0]  next_rdata;
   logic [9:0]  next_result;
   logic        trigger_level;
   logic        source_written;
   logic        auto_fire;
   logic        sw_start;
   logic        start_now;
   logic        store_result;
   logic        ctrl_b_wr;
   logic        ctrl_a_wr;
   logic        wr_pin_dis;
   logic        wr_irq_mask;
   logic        wr_irq_status;
   logic        rd_low;
   logic        rd_high;
   logic        low_read_busy;
   logic        next_enable;
   logic        discard;
   logic [7:0]  ctrl_a_view;

   function automatic logic is_mapped(input logic [5:0] idx);
      is_mapped = (idx == adcrt_pkg::IDX_PIN_DISABLE) || (idx == adcrt_pkg::IDX_CTRL_B)
               || (idx == adcrt_pkg::IDX_RESULT_LOW)  || (idx == adcrt_pkg::IDX_RESULT_HIGH)
               || (idx == adcrt_pkg::IDX_CTRL_A)      || (idx == adcrt_pkg::IDX_IRQ_STATUS)
               || (idx == adcrt_pkg::IDX_IRQ_MASK);
   endfunction : is_mapped

   // ************************************************************
   // APB decode
   // ************************************************************
   // No wait state: read data is captured in setup so it leaves a flop
   assign reg_idx     = apb_req_i.paddr[7:2];
   assign setup_phase = apb_req_i.psel & ~apb_req_i.penable;
   assign pready_o    = apb_req_i.psel & apb_req_i.penable;
   assign access_done = pready_o;
   assign mapped      = is_mapped(reg_idx) && (apb_req_i.paddr[1:0] == 2'h0);
   assign wr_en       = access_done & apb_req_i.pwrite & mapped;
   assign rd_en       = access_done & ~apb_req_i.pwrite & mapped;
   assign wdata       = apb_req_i.pwdata[7:0];
   assign ctrl_b_wr   = wr_en && (reg_idx == adcrt_pkg::IDX_CTRL_B);

   // ************************************************************
   // Register strobes
   // ************************************************************
   assign ctrl_a_wr     = wr_en && (reg_idx == adcrt_pkg::IDX_CTRL_A);
   assign wr_pin_dis    = wr_en && (reg_idx == adcrt_pkg::IDX_PIN_DISABLE);
   assign wr_irq_mask   = wr_en && (reg_idx == adcrt_pkg::IDX_IRQ_MASK);
   assign wr_irq_status = wr_en && (reg_idx == adcrt_pkg::IDX_IRQ_STATUS);
   assign rd_low        = rd_en && (reg_idx == adcrt_pkg::IDX_RESULT_LOW);
   assign rd_high       = rd_en && (reg_idx == adcrt_pkg::IDX_RESULT_HIGH);
   // Low read in flight: data leaves at setup, the lock lands at access,
   // so no store may slip in between
   assign low_read_busy = apb_req_i.psel & ~apb_req_i.pwrite & mapped
                        & (reg_idx == adcrt_pkg::IDX_RESULT_LOW);

   // ************************************************************
   // Result presentation
   // ************************************************************
   always_comb begin
      if (converter_control_b.left_justify_bit) begin
         result_high = conversion_result_bits[9:2];
         result_low  = {conversion_result_bits[1:0], 6'h00};
      end else begin
         result_high = {6'h00, conversion_result_bits[9:8]};
         result_low  = conversion_result_bits[7:0];
      end
   end

   always_comb begin
      ctrl_a_view                           = 8'h00;
      ctrl_a_view[adcrt_pkg::CTRL_A_ENABLE] = converter_enable;
      ctrl_a_view[adcrt_pkg::CTRL_A_START]  = busy;
      ctrl_a_view[adcrt_pkg::CTRL_A_AUTO]   = auto_trigger_enable;
      ctrl_a_view[adcrt_pkg::CTRL_A_FLAG]   = irq_status[adcrt_pkg::IRQ_COMPLETE];
   end

   always_comb begin
      unique case (reg_idx)
         adcrt_pkg::IDX_PIN_DISABLE: next_rdata = analog_pin_input_disable;
         adcrt_pkg::IDX_CTRL_B:      next_rdata = converter_control_b;
         adcrt_pkg::IDX_RESULT_LOW:  next_rdata = result_low;
         adcrt_pkg::IDX_RESULT_HIGH: next_rdata = result_high;
         adcrt_pkg::IDX_CTRL_A:      next_rdata = ctrl_a_view;
         adcrt_pkg::IDX_IRQ_STATUS:  next_rdata = {6'h00, irq_status};
         adcrt_pkg::IDX_IRQ_MASK:    next_rdata = {6'h00, irq_mask};
         default:                    next_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         prdata_o  <= 32'h0000_0000;
         pslverr_o <= 1'b0;
      end else if (setup_phase) begin
         prdata_o  <= {24'h00_0000, next_rdata};
         pslverr_o <= ~mapped;
      end
   end

   // ************************************************************
   // Control registers
   // ************************************************************
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         analog_pin_input_disable <= adcrt_pkg::RST_PIN_DISABLE;
      end else if (wr_pin_dis) begin
         analog_pin_input_disable <= wdata;
      end
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         converter_control_b <= adcrt_pkg::RST_CTRL_B;
      end else if (ctrl_b_wr) begin
         converter_control_b <= wdata;
      end
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         converter_enable    <= 1'b0;
         auto_trigger_enable <= 1'b0;
      end else if (ctrl_a_wr) begin
         converter_enable    <= wdata[adcrt_pkg::CTRL_A_ENABLE];
         auto_trigger_enable <= wdata[adcrt_pkg::CTRL_A_AUTO];
      end
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         irq_mask <= adcrt_pkg::RST_IRQ;
      end else if (wr_irq_mask) begin
         irq_mask <= wdata[1:0];
      end
   end

   // ************************************************************
   // Trigger selection and edge detect
   // ************************************************************
   always_comb begin
      unique case (converter_control_b.trigger_source_field)
         3'h0:    trigger_level = irq_status[adcrt_pkg::IRQ_COMPLETE];
         default: trigger_level = trig_flags_i[converter_control_b.trigger_source_field - 3'h1];
      endcase
   end

   // A write that lands the field on free running marks the edge detect as high, so a flag already set does not fire
   assign source_written = ctrl_b_wr
                        && (wdata[2:0] == adcrt_pkg::SRC_FREE_RUN)
                        && (converter_control_b.trigger_source_field != adcrt_pkg::SRC_FREE_RUN);

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         prev_trigger <= 1'b0;
      end else if (source_written) begin
         prev_trigger <= 1'b1;
      end else begin
         prev_trigger <= trigger_level;
      end
   end

   assign auto_fire = auto_trigger_enable & trigger_level & ~prev_trigger;
   assign sw_start  = ctrl_a_wr && wdata[adcrt_pkg::CTRL_A_START];
   // Enable as it stands after this edge: a write that enables and starts
   // at once is honoured, and a disabling write blocks a late trigger
   assign next_enable = ctrl_a_wr ? wdata[adcrt_pkg::CTRL_A_ENABLE] : converter_enable;
   assign start_now = next_enable & ~busy & (auto_fire | sw_start);

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         busy <= 1'b0;
      end else begin
         if (!next_enable) begin
            busy <= 1'b0;
         end else if (start_now) begin
            busy <= 1'b1;
         end else if (conv_i.done) begin
            busy <= 1'b0;
         end
      end
   end

   // Registered so the converter sees a clean one-cycle pulse
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         conv_start_o <= 1'b0;
      end else begin
         conv_start_o <= start_now;
      end
   end

   assign conv_enable_o  = converter_enable;
   assign conv_bipolar_o = converter_control_b.bipolar_select;

   // ************************************************************
   // Result capture and read lock
   // ************************************************************
   always_comb begin
      if (converter_control_b.bipolar_select) begin
         // Magnitude loses its lsb to make room for the sign
         next_result = conv_i.neg ? 10'(~{1'b0, conv_i.value[9:1]} + 10'h001)
                                  : {1'b0, conv_i.value[9:1]};
      end else begin
         next_result = conv_i.neg ? adcrt_pkg::SATURATED : conv_i.value;
      end
   end

   assign store_result = conv_i.done & busy & ~read_lock & ~low_read_busy;
   assign discard      = conv_i.done & busy & (read_lock | low_read_busy);

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         conversion_result_bits <= adcrt_pkg::RST_RESULT;
      end else if (store_result) begin
         conversion_result_bits <= next_result;
      end
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         read_lock <= 1'b0;
      end else if (rd_high) begin
         read_lock <= 1'b0;
      end else if (rd_low) begin
         read_lock <= 1'b1;
      end
   end

   // ************************************************************
   // Interrupt status, write one to clear, set wins
   // ************************************************************
   logic [1:0] irq_set;
   logic [1:0] irq_clr;

   // Discard marks a result dropped by the read lock
   assign irq_set = {discard, store_result};

   always_comb begin
      irq_clr = 2'h0;
      if (wr_irq_status) begin
         irq_clr = wdata[1:0];
      end else if (ctrl_a_wr) begin
         irq_clr[adcrt_pkg::IRQ_COMPLETE] = wdata[adcrt_pkg::CTRL_A_FLAG];
      end
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         irq_status <= adcrt_pkg::RST_IRQ;
      end else begin
         irq_status <= (irq_status & ~irq_clr) | irq_set;
      end
   end

   assign irq_o = |(irq_status & irq_mask);

   // ************************************************************
   // Pin input disable
   // ************************************************************
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pin_meta <= 8'h00;
         pin_sync <= 8'h00;
      end else begin
         pin_meta <= port_pin_i;
         pin_sync <= pin_meta;
      end
   end

   // Disabled pins read zero whatever the pad does
   assign port_pin_o          = pin_sync & ~analog_pin_input_disable;
   assign pin_buffer_enable_o = ~analog_pin_input_disable;

endmodule : adcrt_core

`default_nettype wire

// File: test/adcrt_chk.sv
/* Port checker for the converter control block.
   Assumes one clock domain and binding onto adcrt_core. */
`timescale 1ns/10ps
`default_nettype none
module adcrt_chk (
   input wire logic                      core_clk_i,
   input wire logic                      reset_n_i,
   input wire adcrt_pkg::adcrt_apb_req_t apb_req_i,
   input wire logic [31:0]               prdata_o,
   input wire logic                      pready_o,
   input wire logic                      pslverr_o,
   input wire logic                      irq_o,
   input wire logic                      conv_start_o,
   input wire logic                      conv_enable_o,
   input wire logic                      conv_bipolar_o,
   input wire logic [7:0]                port_pin_i,
   input wire logic [7:0]                port_pin_o,
   input wire logic [7:0]                pin_buffer_enable_o
);
   // ********
   // Checks
   // ********
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!reset_n_i);
   wire logic wr_acc = apb_req_i.psel && apb_req_i.penable && apb_req_i.pwrite;
   sequence s_setup_bad;
      apb_req_i.psel && !apb_req_i.penable && apb_req_i.paddr[1:0] != 2'h0;
   endsequence
   sequence s_access_err;
      apb_req_i.psel && apb_req_i.penable && pslverr_o;
   endsequence
   a_unaligned_err: assert property (s_setup_bad |=> s_access_err)
      else $error("unaligned access without error");
   a_ready_zero_wait: assert property (pready_o == (apb_req_i.psel && apb_req_i.penable))
      else $error("ready not in first access cycle");
   a_read_upper_zero: assert property (pready_o |-> prdata_o[31:8] == 24'h0)
      else $error("read data upper bits set");
   a_start_single: assert property (conv_start_o |=> !conv_start_o)
      else $error("start pulse longer than one cycle");
   a_start_enabled: assert property (conv_start_o |-> conv_enable_o)
      else $error("start while converter disabled");
   a_enable_by_write: assert property (!$stable(conv_enable_o) |->
      $past(wr_acc && apb_req_i.paddr == {adcrt_pkg::IDX_CTRL_A, 2'h0}))
      else $error("enable changed without write");
   a_bipolar_by_write: assert property (!$stable(conv_bipolar_o) |->
      $past(wr_acc && apb_req_i.paddr == {adcrt_pkg::IDX_CTRL_B, 2'h0}))
      else $error("bipolar changed without write");
   a_pin_masked: assert property ((port_pin_o & ~pin_buffer_enable_o) == 8'h0)
      else $error("disabled pin reads one");
   a_pin_synced: assert property ((port_pin_o & ~$past(port_pin_i, 2)) == 8'h0)
      else $error("pin input not from synchroniser");
   a_irq_clear_write: assert property ($fell(irq_o) |-> $past(wr_acc))
      else $error("interrupt fell without write");
endmodule : adcrt_chk
bind adcrt_core adcrt_chk u_chk (.core_clk_i, .reset_n_i, .apb_req_i, .prdata_o, .pready_o,
   .pslverr_o, .irq_o, .conv_start_o, .conv_enable_o, .conv_bipolar_o, .port_pin_i,
   .port_pin_o, .pin_buffer_enable_o);
`default_nettype wire

// File: test/adcrt_conv_model.sv
/* Behavioural analog converter: done pulse a set latency after start.
   Assumes start and enable from the block, value and latency from bench. */
`timescale 1ns/10ps
`default_nettype none
module adcrt_conv_model (
   input  wire logic                  core_clk_i,
   input  wire logic                  reset_n_i,
   input  wire logic                  start_i,
   input  wire logic                  enable_i,
   input  wire logic [9:0]            value_i,
   input  wire logic                  neg_i,
   input  wire logic [3:0]            lat_i,
   output var adcrt_pkg::adcrt_conv_t conv_o
);
   // ********
   // Converter
   // ********
   logic [3:0] left;
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i || !enable_i) begin
         left <= 4'h0;
      end else if (start_i) begin
         left <= lat_i;
      end else if (left != 4'h0) begin
         left <= left - 4'h1;
      end
   end
   // Lines scrambled outside the pulse so stale data never matches
   always_comb begin
      conv_o.done  = (left == 4'h1);
      conv_o.neg   = conv_o.done ? neg_i : !neg_i;
      conv_o.value = conv_o.done ? value_i : ~value_i;
   end
endmodule : adcrt_conv_model
`default_nettype wire

// File: test/adc_result_trigger_control_bench.sv
/* Self-checking bench for the converter control block.
   Assumes adcrt_core, the converter model and the bound checker. */
`timescale 1ns/10ps
`default_nettype none
module adc_result_trigger_control_bench;
   // ********
   // Stimulus
   // ********
   localparam logic [7:0] A_DIS = {adcrt_pkg::IDX_PIN_DISABLE, 2'h0};
   localparam logic [7:0] A_CB  = {adcrt_pkg::IDX_CTRL_B, 2'h0};
   localparam logic [7:0] A_LO  = {adcrt_pkg::IDX_RESULT_LOW, 2'h0};
   localparam logic [7:0] A_HI  = {adcrt_pkg::IDX_RESULT_HIGH, 2'h0};
   localparam logic [7:0] A_CA  = {adcrt_pkg::IDX_CTRL_A, 2'h0};
   localparam logic [7:0] A_ST  = {adcrt_pkg::IDX_IRQ_STATUS, 2'h0};
   localparam logic [7:0] A_MK  = {adcrt_pkg::IDX_IRQ_MASK, 2'h0};
   logic                      core_clk_i = 1'b0;
   logic                      reset_n_i  = 1'b0;
   adcrt_pkg::adcrt_apb_req_t req = '0;
   adcrt_pkg::adcrt_conv_t    conv;
   logic [31:0]               prdata;
   logic                      pready, pslverr, irq, start, enable, bipolar;
   logic [6:0]                trig = 7'h0;
   logic [7:0]                pin_in = 8'h0;
   logic [7:0]                pin_out, buf_en;
   logic [9:0]                value = 10'h0;
   logic                      neg = 1'b0;
   logic [3:0]                lat = 4'h1;
   logic [32:0]               exp_q[$];
   int                        mismatches = 0;
   int                        checks_done = 0;
   int                        starts = 0;
   always #12.5 core_clk_i = ~core_clk_i;
   adcrt_core dut (.core_clk_i, .reset_n_i, .apb_req_i(req), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .irq_o(irq), .conv_i(conv), .trig_flags_i(trig),
      .conv_start_o(start), .conv_enable_o(enable), .conv_bipolar_o(bipolar),
      .port_pin_i(pin_in), .port_pin_o(pin_out), .pin_buffer_enable_o(buf_en));
   adcrt_conv_model model (.core_clk_i, .reset_n_i, .start_i(start), .enable_i(enable),
      .value_i(value), .neg_i(neg), .lat_i(lat), .conv_o(conv));
   task automatic check(input logic [32:0] got, input logic [32:0] exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : give_verdict
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      req.paddr <= a;
      req.pwrite <= wr;
      req.pwdata <= d;
      req.psel <= 1'b1;
      @(posedge core_clk_i);
      req.penable <= 1'b1;
      @(posedge core_clk_i);
      while (pready !== 1'b1) @(posedge core_clk_i);
      req.psel <= 1'b0;
      req.penable <= 1'b0;
      @(posedge core_clk_i);
   endtask : apb
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic err = 1'b0);
      exp_q.push_back({err, 24'h0, e});
      apb(1'b0, a, 32'h0);
   endtask : rd
   task automatic rd_res(input logic [9:0] r, input logic lj);
      rd(A_LO, lj ? {r[1:0], 6'h0} : r[7:0]);
      rd(A_HI, lj ? r[9:2] : {6'h0, r[9:8]});
   endtask : rd_res
   task automatic wait_done;
      while (conv.done !== 1'b1) @(posedge core_clk_i);
      repeat (2) @(posedge core_clk_i);
   endtask : wait_done
   task automatic convert(input logic [9:0] v, input logic n);
      value <= v;
      neg <= n;
      lat <= 4'($urandom_range(15, 1));
      apb(1'b1, A_CA, 32'hc0);
      wait_done();
   endtask : convert
   function automatic logic [9:0] code(input logic [9:0] v, input logic n, input logic bip);
      if (bip) return n ? 10'h0 - {1'b0, v[9:1]} : {1'b0, v[9:1]};
      return n ? adcrt_pkg::SATURATED : v;
   endfunction : code
   // ********
   // Monitor
   // ********
   always @(posedge core_clk_i) begin
      if (start === 1'b1) starts++;
      if (req.psel && req.penable && !req.pwrite && pready === 1'b1 && exp_q.size() != 0)
         check({pslverr, prdata}, exp_q.pop_front());
   end
   initial begin
      repeat (20000) @(posedge core_clk_i);
      mismatches++;
      $display("mismatch at %0t: timeout", $time);
      give_verdict();
   end
   initial begin
      logic [9:0] v, w;
      logic [7:0] d;
      int         n;
      void'($urandom(32'h8e44));
      repeat (3) @(posedge core_clk_i);
      reset_n_i <= 1'b1;
      @(posedge core_clk_i);
      check({25'h0, buf_en}, 33'hff);
      rd(A_DIS, 8'h0);
      rd(A_LO, 8'h0);
      rd(A_HI, 8'h0);
      rd(A_CB, 8'h0);
      rd(8'h02, 8'h0, 1'b1);
      rd(8'hfc, 8'h0, 1'b1);
      $display("test reset done");
      d = 8'($urandom);
      pin_in <= 8'($urandom);
      apb(1'b1, A_DIS, {24'h0, d});
      check({25'h0, pin_out}, {25'h0, pin_in & ~d});
      check({25'h0, buf_en}, {25'h0, ~d});
      rd(A_DIS, d);
      apb(1'b1, A_CB, 32'h28);
      rd(A_CB, 8'h28);
      $display("test registers done");
      apb(1'b1, A_MK, 32'h1);
      v = 10'($urandom);
      convert(v, 1'b0);
      check({32'h0, irq}, 33'h1);
      apb(1'b1, A_MK, 32'h0);
      check({32'h0, irq}, 33'h0);
      apb(1'b1, A_MK, 32'h1);
      rd_res(v, 1'b0);
      apb(1'b1, A_CB, 32'h10);
      rd_res(v, 1'b1);
      rd(A_ST, 8'h01);
      apb(1'b1, A_ST, 32'h1);
      check({32'h0, irq}, 33'h0);
      $display("test result done");
      rd(A_LO, {v[1:0], 6'h0});
      w = 10'($urandom);
      convert(w, 1'b0);
      rd(A_HI, v[9:2]);
      convert(w, 1'b0);
      rd_res(w, 1'b1);
      apb(1'b1, A_ST, 32'h3);
      $display("test lock done");
      for (int k = 1; k < 4; k++) begin
         apb(1'b1, A_CB, {24'h0, k[1], 7'h0});
         check({32'h0, bipolar}, {32'h0, k[1]});
         v = 10'($urandom);
         convert(v, k[0]);
         rd_res(code(v, k[0], k[1]), 1'b0);
      end
      $display("test format done");
      apb(1'b1, A_CA, 32'h80);
      n = starts;
      trig <= 7'h01;
      apb(1'b1, A_CB, 32'h1);
      check(33'(starts - n), 33'h0);
      trig <= 7'h0;
      apb(1'b1, A_CA, 32'ha0);
      for (int s = 1; s < 8; s++) begin
         n = starts;
         if (s[0]) begin
            trig <= 7'h1 << (s - 1);
            apb(1'b1, A_CB, s);
         end else begin
            apb(1'b1, A_CB, s);
            trig <= 7'h1 << (s - 1);
         end
         wait_done();
         check(33'(starts - n), 33'h1);
         trig <= 7'h0;
         @(posedge core_clk_i);
      end
      n = starts;
      apb(1'b1, A_CB, 32'h0);
      repeat (4) @(posedge core_clk_i);
      check(33'(starts - n), 33'h0);
      apb(1'b1, A_ST, 32'h1);
      n = starts;
      apb(1'b1, A_CA, 32'he0);
      wait_done();
      wait_done();
      check(33'(starts - n), 33'h2);
      check({32'h0, enable}, 33'h1);
      apb(1'b1, A_CA, 32'h0);
      check({32'h0, enable}, 33'h0);
      $display("test trigger done");
      give_verdict();
   end
endmodule : adc_result_trigger_control_bench
`default_nettype wire
